// ### inc/uapc_pkg.sv
// constants for the phone audio control register bank
package uapc_pkg;
    localparam logic [7:0] ADDR_GEN_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SER_CTRL = 8'h01;
    localparam logic [7:0] ADDR_FS_CFG = 8'h02;
    localparam logic [7:0] ADDR_WR_CNT = 8'h05;
    localparam logic [7:0] ADDR_RD_CNT = 8'h06;
    localparam logic [7:0] ADDR_AUX_DATA = 8'h12;
    localparam logic [7:0] ADDR_AUX_DIR = 8'h13;
    localparam logic [7:0] ADDR_AUX_POL = 8'h14;
    localparam logic [7:0] ADDR_AUX_WAKE = 8'h15;
    localparam logic [7:0] ADDR_SRAM_DLY = 8'h17;
    localparam logic [7:0] ADDR_POLL = 8'h18;
    localparam logic [7:0] ADDR_AUDIO_CTRL = 8'h1F;
    localparam logic [7:0] ADDR_MIC_MUTE = 8'h20;
    localparam logic [7:0] ADDR_SPK_MUTE = 8'h21;
    localparam logic [7:0] ADDR_MIC_GAIN_LO = 8'h22;
    localparam logic [7:0] ADDR_MIC_GAIN_HI = 8'h23;
    localparam logic [7:0] ADDR_INT_LAST = 8'h30;
    localparam logic [7:0] ADDR_PERIPH_FIRST = 8'hC0;
    // reset values
    localparam logic [7:0] RST_GEN_CTRL = 8'h40;
    localparam logic [15:0] RST_MIC_GAIN = 16'hF600;
    // writable masks, reserved bits dropped
    localparam logic [7:0] MASK_GEN_CTRL = 8'hDD;
    localparam logic [7:0] MASK_SER_CTRL = 8'hCD;
    localparam logic [7:0] MASK_FS_CFG = 8'hE0;
    localparam logic [7:0] MASK_AUX = 8'h7F;
    localparam logic [7:0] MASK_AUX_DIR = 8'h6F;
    localparam logic [7:0] MASK_SRAM_DLY = 8'h30;
    localparam logic [7:0] MASK_AUDIO_CTRL = 8'h7E;
    // field positions
    localparam int GC_EXT_RST = 0;
    localparam int GC_SUB_RST = 2;
    localparam int GC_AUX_HA = 3;
    localparam int GC_AUX_SUSP = 4;
    localparam int GC_USB_RST_DIS = 6;
    localparam int GC_PCLK_DIS = 7;
    localparam int SB_DOUT_EN = 0;
    localparam int SB_CLK_INV = 2;
    localparam int SB_FORCE_LOW = 3;
    localparam int SB_CLK_SEL = 6;
    localparam int FS_MASTER_N = 5;
    localparam int FS_OUT_INV = 6;
    localparam int FS_SRC = 7;
    localparam int SD_DLY = 4;
    localparam int PL_EN = 6;
    localparam int AC_TDM_RST = 1;
    localparam int AC_MASTER = 2;
    localparam int AC_CLK_INV = 3;
    localparam int AC_USB_RST_EN = 4;
    localparam int AC_DOUT_DIS = 5;
    localparam int AC_FORCE_LOW = 6;
    localparam int AUX_LINES = 7;
    // doubler high period and strobe delay, ns
    localparam int CLK_HIGH_NS_1 = 30;
    localparam int CLK_HIGH_NS_2 = 60;
    localparam int CLK_HIGH_NS_3 = 90;
    localparam int WR_DLY_NS_0 = 8;
    localparam int WR_DLY_NS_1 = 4;
    localparam int WR_DLY_NS_2 = 12;
    localparam int WR_DLY_NS_3 = 16;
    localparam logic [1:0] POLL_ON = 2'b11;
    // mic gain step thresholds
    localparam logic [15:0] GAIN_UP4_MIN = 16'hFE00;
    localparam logic [15:0] GAIN_UP2_MIN = 16'hFB00;
    localparam logic [15:0] GAIN_UNITY_MIN = 16'hF200;
    localparam logic [15:0] GAIN_DN2_MIN = 16'hD800;
    localparam logic [15:0] GAIN_DN4_MIN = 16'h8000;
    localparam logic [2:0] STEP_UP4 = 3'h4;
    localparam logic [2:0] STEP_UP2 = 3'h3;
    localparam logic [2:0] STEP_UNITY = 3'h2;
    localparam logic [2:0] STEP_DN2 = 3'h1;
    localparam logic [2:0] STEP_DN4 = 3'h0;
endpackage

// ### hdl/uapc_regs.sv
// register bank and control decode of the phone audio controller
`timescale 1ns/100ps
`default_nettype none
module uapc_regs (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic audio_class_mode,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [7:0] periph_rdata,
    output logic periph_wr,
    output logic periph_rd,
    output logic [5:0] peripheral_address_line,
    output logic [7:0] periph_wdata,
    input wire logic vendor_wr_byte,
    input wire logic vendor_rd_byte,
    input wire logic vendor_cmd_start,
    input wire logic [6:0] aux_in,
    output logic [6:0] aux_out,
    output logic [6:0] aux_oe,
    input wire logic suspend_active,
    output logic wake_event,
    output logic parallel_clock_output_disable,
    output logic usb_reset_response_en,
    output logic subscriber_bus_reset,
    output logic peripheral_reset_out_n,
    output logic clk_doubler_en,
    output logic [6:0] clk_high_ns,
    output logic dout_force_low,
    output logic serial_clk_invert,
    output logic dout_enable,
    output logic frame_sync_src_serial_data_clock,
    output logic serial_pins_output,
    output logic tdm_clk_out_invert,
    output logic tdm_reset,
    output logic [4:0] wr_strobe_delay_ns,
    output logic poll_active,
    output logic [5:0] poll_address,
    output logic mic_muted,
    output logic speaker_muted,
    output logic [2:0] mic_gain_step
);
    logic [7:0] general_control;
    logic [7:0] serial_bus_control;
    logic [7:0] frame_sync_master_config;
    logic [7:0] write_byte_count;
    logic [7:0] read_byte_count;
    logic [7:0] spare_line_levels;
    logic [7:0] spare_line_directions;
    logic [7:0] wake_invert_bits;
    logic [7:0] wake_select_bits;
    logic [7:0] sram_write_delay;
    logic [7:0] interrupt_poll_address;
    logic [7:0] audio_class_control;
    logic [7:0] mic_mute_field;
    logic [7:0] speaker_mute_field;
    logic [15:0] mic_gain_field;
    logic [6:0] aux_meta;
    logic [6:0] aux_sync;

    // address decode
    wire internal_hit = reg_addr <= uapc_pkg::ADDR_INT_LAST;
    wire periph_hit = reg_addr >= uapc_pkg::ADDR_PERIPH_FIRST;
    wire int_wr = reg_wr && internal_hit;
    wire wr_gen = int_wr && reg_addr == uapc_pkg::ADDR_GEN_CTRL;
    wire wr_ser = int_wr && reg_addr == uapc_pkg::ADDR_SER_CTRL;
    wire wr_fs = int_wr && reg_addr == uapc_pkg::ADDR_FS_CFG;
    wire wr_aux_d = int_wr && reg_addr == uapc_pkg::ADDR_AUX_DATA;
    wire wr_aux_c = int_wr && reg_addr == uapc_pkg::ADDR_AUX_DIR;
    wire wr_aux_p = int_wr && reg_addr == uapc_pkg::ADDR_AUX_POL;
    wire wr_aux_w = int_wr && reg_addr == uapc_pkg::ADDR_AUX_WAKE;
    wire wr_sram = int_wr && reg_addr == uapc_pkg::ADDR_SRAM_DLY;
    wire wr_poll = int_wr && reg_addr == uapc_pkg::ADDR_POLL;
    wire wr_audio = int_wr && reg_addr == uapc_pkg::ADDR_AUDIO_CTRL;
    wire wr_mmute = int_wr && reg_addr == uapc_pkg::ADDR_MIC_MUTE;
    wire wr_smute = int_wr && reg_addr == uapc_pkg::ADDR_SPK_MUTE;
    wire wr_glo = int_wr && reg_addr == uapc_pkg::ADDR_MIC_GAIN_LO;
    wire wr_ghi = int_wr && reg_addr == uapc_pkg::ADDR_MIC_GAIN_HI;

    // aux 4 has no direction bit of its own
    wire [6:0] eff_dir = {spare_line_directions[6:5], spare_line_directions[3],
                          spare_line_directions[3:0]};
    // repurposed lines are driven by the alternate function
    wire [6:0] alt_sel = {4'h0, general_control[uapc_pkg::GC_AUX_SUSP],
                          {2{general_control[uapc_pkg::GC_AUX_HA]}}};
    wire [6:0] alt_val = {4'h0, ~suspend_active, peripheral_address_line[5:4]};
    wire [6:0] next_aux_oe = eff_dir | alt_sel;
    // writes only reach the pin where the line is an output
    wire [6:0] next_aux_out = (alt_sel & alt_val) |
                              (~alt_sel & eff_dir & spare_line_levels[6:0]);
    // polarity only feeds the wake comparator, data reads see raw pins
    wire [6:0] wake_lvl = aux_sync ^ wake_invert_bits[6:0];
    wire next_wake = |(wake_lvl & wake_select_bits[6:0]);

    // read mux, unmapped internal offsets read zero
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr)
            uapc_pkg::ADDR_GEN_CTRL: rd_mux = general_control;
            uapc_pkg::ADDR_SER_CTRL: rd_mux = serial_bus_control;
            uapc_pkg::ADDR_FS_CFG: rd_mux = frame_sync_master_config;
            uapc_pkg::ADDR_WR_CNT: rd_mux = write_byte_count;
            uapc_pkg::ADDR_RD_CNT: rd_mux = read_byte_count;
            uapc_pkg::ADDR_AUX_DATA: rd_mux = {1'b0, aux_sync};
            uapc_pkg::ADDR_AUX_DIR: rd_mux = spare_line_directions;
            uapc_pkg::ADDR_AUX_POL: rd_mux = wake_invert_bits;
            uapc_pkg::ADDR_AUX_WAKE: rd_mux = wake_select_bits;
            uapc_pkg::ADDR_SRAM_DLY: rd_mux = sram_write_delay;
            uapc_pkg::ADDR_POLL: rd_mux = interrupt_poll_address;
            uapc_pkg::ADDR_AUDIO_CTRL: rd_mux = audio_class_control;
            uapc_pkg::ADDR_MIC_MUTE: rd_mux = mic_mute_field;
            uapc_pkg::ADDR_SPK_MUTE: rd_mux = speaker_mute_field;
            uapc_pkg::ADDR_MIC_GAIN_LO: rd_mux = mic_gain_field[7:0];
            uapc_pkg::ADDR_MIC_GAIN_HI: rd_mux = mic_gain_field[15:8];
            default: rd_mux = 8'h00;
        endcase
    end
    wire [7:0] next_rdata = periph_hit ? periph_rdata : rd_mux;

    // doubler high period per select code
    logic [6:0] next_high_ns;
    wire [1:0] clk_sel = serial_bus_control[uapc_pkg::SB_CLK_SEL +: 2];
    always_comb begin
        case (clk_sel)
            2'b01: next_high_ns = 7'(uapc_pkg::CLK_HIGH_NS_1);
            2'b10: next_high_ns = 7'(uapc_pkg::CLK_HIGH_NS_2);
            2'b11: next_high_ns = 7'(uapc_pkg::CLK_HIGH_NS_3);
            default: next_high_ns = 7'h00;
        endcase
    end

    // write strobe delay per code; note 01 is the shortest, not 00
    logic [4:0] next_dly;
    always_comb begin
        case (sram_write_delay[uapc_pkg::SD_DLY +: 2])
            2'b00: next_dly = 5'(uapc_pkg::WR_DLY_NS_0);
            2'b01: next_dly = 5'(uapc_pkg::WR_DLY_NS_1);
            2'b10: next_dly = 5'(uapc_pkg::WR_DLY_NS_2);
            default: next_dly = 5'(uapc_pkg::WR_DLY_NS_3);
        endcase
    end

    // five-step mic gain by range, top of range is the loudest
    logic [2:0] next_step;
    always_comb begin
        if (mic_gain_field >= uapc_pkg::GAIN_UP4_MIN || mic_gain_field < uapc_pkg::GAIN_DN4_MIN) begin
            next_step = uapc_pkg::STEP_UP4;
        end else if (mic_gain_field >= uapc_pkg::GAIN_UP2_MIN) begin
            next_step = uapc_pkg::STEP_UP2;
        end else if (mic_gain_field >= uapc_pkg::GAIN_UNITY_MIN) begin
            next_step = uapc_pkg::STEP_UNITY;
        end else if (mic_gain_field >= uapc_pkg::GAIN_DN2_MIN) begin
            next_step = uapc_pkg::STEP_DN2;
        end else begin
            next_step = uapc_pkg::STEP_DN4;
        end
    end

    // mode-dependent serial controls: audio class mode uses its own register
    wire gc_usb = ~general_control[uapc_pkg::GC_USB_RST_DIS];
    wire ac_usb = audio_class_control[uapc_pkg::AC_USB_RST_EN];
    wire next_usb_en = audio_class_mode ? ac_usb : gc_usb;
    wire next_sub_rst = ~audio_class_mode &&
                        general_control[uapc_pkg::GC_SUB_RST];
    wire next_force = audio_class_mode ? audio_class_control[uapc_pkg::AC_FORCE_LOW] :
                      serial_bus_control[uapc_pkg::SB_FORCE_LOW];
    wire next_dout_en = audio_class_mode ? ~audio_class_control[uapc_pkg::AC_DOUT_DIS] :
                        serial_bus_control[uapc_pkg::SB_DOUT_EN];
    wire next_clk_inv = audio_class_mode ? audio_class_control[uapc_pkg::AC_CLK_INV] :
                        serial_bus_control[uapc_pkg::SB_CLK_INV];
    wire next_master = audio_class_mode ? audio_class_control[uapc_pkg::AC_MASTER] :
                       ~frame_sync_master_config[uapc_pkg::FS_MASTER_N];
    wire next_out_inv = ~audio_class_mode && next_master &&
                        frame_sync_master_config[uapc_pkg::FS_OUT_INV];
    wire next_tdm_rst = audio_class_mode &&
                        audio_class_control[uapc_pkg::AC_TDM_RST];
    wire next_poll = interrupt_poll_address[uapc_pkg::PL_EN +: 2] == uapc_pkg::POLL_ON;

    // aux input synchroniser, pins are asynchronous
    always_ff @(posedge ref_clk) begin
        aux_meta <= aux_in;
        aux_sync <= aux_meta;
    end

    // software registers, reserved bits masked on write
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            general_control <= uapc_pkg::RST_GEN_CTRL;
            serial_bus_control <= 8'h00;
            frame_sync_master_config <= 8'h00;
            spare_line_levels <= 8'h00;
            spare_line_directions <= 8'h00;
            wake_invert_bits <= 8'h00;
            wake_select_bits <= 8'h00;
            sram_write_delay <= 8'h00;
            interrupt_poll_address <= 8'h00;
            audio_class_control <= 8'h00;
            mic_mute_field <= 8'h00;
            speaker_mute_field <= 8'h00;
            mic_gain_field <= uapc_pkg::RST_MIC_GAIN;
        end else begin
            if (wr_gen) general_control <= reg_wdata & uapc_pkg::MASK_GEN_CTRL;
            if (wr_ser) serial_bus_control <= reg_wdata & uapc_pkg::MASK_SER_CTRL;
            if (wr_fs) frame_sync_master_config <= reg_wdata & uapc_pkg::MASK_FS_CFG;
            if (wr_aux_d) spare_line_levels <= reg_wdata & uapc_pkg::MASK_AUX;
            if (wr_aux_c) spare_line_directions <= reg_wdata & uapc_pkg::MASK_AUX_DIR;
            if (wr_aux_p) wake_invert_bits <= reg_wdata & uapc_pkg::MASK_AUX;
            if (wr_aux_w) wake_select_bits <= reg_wdata & uapc_pkg::MASK_AUX;
            if (wr_sram) sram_write_delay <= reg_wdata & uapc_pkg::MASK_SRAM_DLY;
            if (wr_poll) interrupt_poll_address <= reg_wdata;
            if (wr_audio) audio_class_control <= reg_wdata & uapc_pkg::MASK_AUDIO_CTRL;
            if (wr_mmute) mic_mute_field <= reg_wdata;
            if (wr_smute) speaker_mute_field <= reg_wdata;
            if (wr_glo) mic_gain_field[7:0] <= reg_wdata;
            if (wr_ghi) mic_gain_field[15:8] <= reg_wdata;
        end
    end

    // vendor byte counters restart with each vendor command
    always_ff @(posedge ref_clk) begin
        if (rst || vendor_cmd_start) begin
            write_byte_count <= 8'h00;
            read_byte_count <= 8'h00;
        end else begin
            if (vendor_wr_byte) write_byte_count <= write_byte_count + 8'h01;
            if (vendor_rd_byte) read_byte_count <= read_byte_count + 8'h01;
        end
    end

    // bus answer and peripheral forwarding, one cycle after the request
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
            periph_wr <= 1'b0;
            periph_rd <= 1'b0;
            peripheral_address_line <= 6'h00;
            periph_wdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : reg_rdata;
            reg_rvalid <= reg_rd;
            periph_wr <= reg_wr && periph_hit;
            periph_rd <= reg_rd && periph_hit;
            if ((reg_wr || reg_rd) && periph_hit) begin
                peripheral_address_line <= reg_addr[5:0];
                periph_wdata <= reg_wdata;
            end
        end
    end

    // registered control outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            aux_out <= 7'h00;
            aux_oe <= 7'h00;
            wake_event <= 1'b0;
            parallel_clock_output_disable <= 1'b1;
            usb_reset_response_en <= 1'b0;
            subscriber_bus_reset <= 1'b0;
            peripheral_reset_out_n <= 1'b0;
            clk_doubler_en <= 1'b0;
            clk_high_ns <= 7'h00;
            dout_force_low <= 1'b0;
            serial_clk_invert <= 1'b0;
            dout_enable <= 1'b0;
            frame_sync_src_serial_data_clock <= 1'b0;
            serial_pins_output <= 1'b0;
            tdm_clk_out_invert <= 1'b0;
            tdm_reset <= 1'b0;
            wr_strobe_delay_ns <= 5'h00;
            poll_active <= 1'b0;
            poll_address <= 6'h00;
            mic_muted <= 1'b0;
            speaker_muted <= 1'b0;
            mic_gain_step <= uapc_pkg::STEP_UNITY;
        end else begin
            aux_out <= next_aux_out;
            aux_oe <= next_aux_oe;
            wake_event <= next_wake;
            parallel_clock_output_disable <= general_control[uapc_pkg::GC_PCLK_DIS];
            usb_reset_response_en <= next_usb_en;
            subscriber_bus_reset <= next_sub_rst;
            peripheral_reset_out_n <= general_control[uapc_pkg::GC_EXT_RST];
            clk_doubler_en <= ~audio_class_mode && clk_sel != 2'b00;
            clk_high_ns <= next_high_ns;
            dout_force_low <= next_force;
            serial_clk_invert <= next_clk_inv;
            dout_enable <= next_dout_en;
            frame_sync_src_serial_data_clock <= frame_sync_master_config[uapc_pkg::FS_SRC];
            serial_pins_output <= next_master;
            tdm_clk_out_invert <= next_out_inv;
            tdm_reset <= next_tdm_rst;
            wr_strobe_delay_ns <= next_dly;
            poll_active <= next_poll;
            poll_address <= interrupt_poll_address[5:0];
            mic_muted <= mic_mute_field != 8'h00;
            speaker_muted <= speaker_mute_field != 8'h00;
            mic_gain_step <= next_step;
        end
    end
endmodule
`default_nettype wire

// ### test/uapc_regs_monitor.sv
// timing and decode assertions on the control register bank ports
`timescale 1ns/100ps
`default_nettype none
module uapc_regs_monitor (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic audio_class_mode,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rvalid,
    input wire logic periph_wr,
    input wire logic periph_rd,
    input wire logic [5:0] peripheral_address_line,
    input wire logic parallel_clock_output_disable,
    input wire logic peripheral_reset_out_n,
    input wire logic serial_pins_output,
    input wire logic poll_active,
    input wire logic mic_muted,
    input wire logic speaker_muted
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_read_answered: assert property (reg_rd |=> reg_rvalid)
        else $error("read request got no answer");
    a_periph_forward: assert property (reg_wr && reg_addr >= 8'hC0 |=> periph_wr
        && peripheral_address_line == $past(reg_addr[5:0])) else $error("forward missing");
    a_periph_read: assert property (reg_rd && reg_addr >= 8'hC0 |=> periph_rd)
        else $error("peripheral read strobe missing");
    a_internal_kept: assert property (reg_wr && reg_addr < 8'hC0 |=> !periph_wr)
        else $error("internal write leaked to peripheral bus");
    a_pclk_gate: assert property (reg_wr && reg_addr == 8'h00 |-> ##2
        parallel_clock_output_disable == $past(reg_wdata[7], 2)) else $error("clock gate");
    a_reset_pin: assert property (reg_wr && reg_addr == 8'h00 |-> ##2
        peripheral_reset_out_n == $past(reg_wdata[0], 2)) else $error("reset pin level");
    a_master_pins: assert property (reg_wr && reg_addr == 8'h02 && !audio_class_mode
        ##1 !audio_class_mode |=> serial_pins_output == !$past(reg_wdata[5], 2))
        else $error("serial pin direction");
    a_poll_gate: assert property (reg_wr && reg_addr == 8'h18 |-> ##2
        poll_active == ($past(reg_wdata[7:6], 2) == 2'b11)) else $error("poll enable");
    a_mic_mute: assert property (reg_wr && reg_addr == 8'h20 |-> ##2
        mic_muted == (|$past(reg_wdata, 2))) else $error("mic mute");
    a_spk_mute: assert property (reg_wr && reg_addr == 8'h21 |-> ##2
        speaker_muted == (|$past(reg_wdata, 2))) else $error("speaker mute");
endmodule
bind uapc_regs uapc_regs_monitor u_uapc_regs_monitor (.ref_clk, .rst, .audio_class_mode,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rvalid, .periph_wr, .periph_rd,
    .peripheral_address_line, .parallel_clock_output_disable, .peripheral_reset_out_n,
    .serial_pins_output, .poll_active, .mic_muted, .speaker_muted);
`default_nettype wire

// ### test/uapc_periph_model.sv
// peripheral bus device model: a small register file behind the forwarded window
`timescale 1ns/100ps
`default_nettype none
module uapc_periph_model (
    input wire logic ref_clk,
    input wire logic [7:0] reg_addr,
    input wire logic periph_wr,
    input wire logic [5:0] peripheral_address_line,
    input wire logic [7:0] periph_wdata,
    output logic [7:0] periph_rdata
);
    logic [7:0] mem [64];
    initial foreach (mem[i]) mem[i] = 8'hA5 ^ 8'(i);
    // forwarded writes land at the address shown on the address lines
    always @(posedge ref_clk) begin
        if (periph_wr) begin
            mem[peripheral_address_line] <= periph_wdata;
        end
    end
    // read data is combinational; when not selected show the inverse so stale data never matches
    assign periph_rdata = (reg_addr >= 8'hC0) ? mem[reg_addr[5:0]] : ~mem[reg_addr[5:0]];
endmodule
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the control register bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
    typedef struct packed {logic [7:0] addr, wdata, rd_exp, out_exp;} uapc_row_s;
    localparam int NROWS = 33;
    logic ref_clk = 1'b0, rst = 1'b1, audio_class_mode = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, periph_rdata, periph_wdata;
    logic vendor_wr_byte = 1'b0, vendor_rd_byte = 1'b0, vendor_cmd_start = 1'b0;
    logic suspend_active = 1'b0, reg_rvalid, periph_wr, periph_rd, wake_event, poll_active;
    logic [6:0] aux_ext = 7'h00, aux_in, aux_out, aux_oe, clk_high_ns;
    logic [5:0] peripheral_address_line, poll_address;
    logic parallel_clock_output_disable, usb_reset_response_en, subscriber_bus_reset;
    logic peripheral_reset_out_n, clk_doubler_en, dout_force_low, serial_clk_invert;
    logic dout_enable, frame_sync_src_serial_data_clock, serial_pins_output, tdm_clk_out_invert, tdm_reset;
    logic mic_muted, speaker_muted;
    logic [4:0] wr_strobe_delay_ns;
    logic [2:0] mic_gain_step;
    logic [7:0] out_seen;
    int errors = 0, num_checks = 0;
    // addr, data written, readback, watched output
    uapc_row_s rows [NROWS] = '{
        '{8'h00, 8'hFF, 8'hDD, 8'h01}, '{8'h00, 8'h01, 8'h01, 8'h00},
        '{8'h01, 8'h40, 8'h40, 8'h1E}, '{8'h01, 8'h80, 8'h80, 8'h3C},
        '{8'h01, 8'hFF, 8'hCD, 8'h5A}, '{8'h01, 8'h00, 8'h00, 8'h00},
        '{8'h02, 8'hE0, 8'hE0, 8'h00}, '{8'h02, 8'h00, 8'h00, 8'h01},
        '{8'h17, 8'hFF, 8'h30, 8'h10}, '{8'h17, 8'h00, 8'h00, 8'h08},
        '{8'h17, 8'h10, 8'h10, 8'h04}, '{8'h17, 8'h20, 8'h20, 8'h0C},
        '{8'h18, 8'hC5, 8'hC5, 8'h01}, '{8'h18, 8'h85, 8'h85, 8'h00},
        '{8'h20, 8'h01, 8'h01, 8'h01}, '{8'h20, 8'h00, 8'h00, 8'h00},
        '{8'h21, 8'h80, 8'h80, 8'h01}, '{8'h23, 8'hFE, 8'hFE, 8'h04},
        '{8'h23, 8'hFB, 8'hFB, 8'h03}, '{8'h23, 8'hF2, 8'hF2, 8'h02},
        '{8'h23, 8'hF1, 8'hF1, 8'h01}, '{8'h23, 8'hD7, 8'hD7, 8'h00},
        '{8'h23, 8'h80, 8'h80, 8'h00}, '{8'h22, 8'hFF, 8'hFF, 8'h00},
        '{8'h23, 8'hF1, 8'hF1, 8'h01}, '{8'h23, 8'hFA, 8'hFA, 8'h02},
        '{8'h31, 8'hFF, 8'h00, 8'h00}, '{8'h05, 8'hFF, 8'h00, 8'h00},
        '{8'h12, 8'hFF, 8'h00, 8'h00}, '{8'h13, 8'h0F, 8'h0F, 8'h1F},
        '{8'h15, 8'h01, 8'h01, 8'h01}, '{8'h14, 8'h01, 8'h01, 8'h00},
        '{8'h13, 8'hF7, 8'h67, 8'h67}};
    // the wire level: driven lines show the design, the rest the outside world
    assign aux_in = (aux_oe & aux_out) | (~aux_oe & aux_ext);
    uapc_regs u_uapc_regs (.*);
    uapc_periph_model u_uapc_periph_model (.ref_clk(ref_clk), .reg_addr(reg_addr),
        .periph_wr(periph_wr), .peripheral_address_line(peripheral_address_line),
        .periph_wdata(periph_wdata), .periph_rdata(periph_rdata));
    // pick the output that belongs to the register last addressed
    always_comb begin
        case (reg_addr)
            8'h00: out_seen = 8'(parallel_clock_output_disable);
            8'h01: out_seen = 8'(clk_high_ns);
            8'h02: out_seen = 8'(serial_pins_output);
            8'h12: out_seen = 8'(aux_out);
            8'h13: out_seen = 8'(aux_oe);
            8'h14, 8'h15: out_seen = 8'(wake_event);
            8'h17: out_seen = 8'(wr_strobe_delay_ns);
            8'h18: out_seen = 8'(poll_active);
            8'h20: out_seen = 8'(mic_muted);
            8'h21: out_seen = 8'(speaker_muted);
            8'h22, 8'h23: out_seen = 8'(mic_gain_step);
            default: out_seen = 8'h00;
        endcase
    end
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // answer and derived outputs are both settled one edge after the request is taken
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge ref_clk);
        errors++;
        print_verdict();
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < NROWS; i++) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr);
            chk("readback", rows[i].rd_exp, reg_rdata);
            chk("derived output", rows[i].out_exp, out_seen);
        end
        // serial controls outside audio mode; undriven aux lines come from outside
        @(posedge ref_clk) aux_ext <= 7'h18;
        wr(8'h01, 8'h4D);
        wr(8'h02, 8'hC0);
        rd(8'h12);
        chk("aux pins", 8'h7F, reg_rdata);
        chk("aux out", 8'h67, 8'(aux_out));
        chk("serial ctrl", 8'h3F, {2'h0, clk_doubler_en, tdm_clk_out_invert, dout_force_low,
            serial_clk_invert, dout_enable, frame_sync_src_serial_data_clock});
        chk("poll addr", 8'h05, 8'(poll_address));
        // byte counters count clock cycles with the strobe high and clear on a new command
        @(posedge ref_clk) vendor_wr_byte <= 1'b1;
        repeat (3) @(posedge ref_clk);
        vendor_wr_byte <= 1'b0;
        vendor_rd_byte <= 1'b1;
        repeat (2) @(posedge ref_clk);
        vendor_rd_byte <= 1'b0;
        rd(8'h05);
        chk("write count", 8'h03, reg_rdata);
        rd(8'h06);
        chk("read count", 8'h02, reg_rdata);
        @(posedge ref_clk) vendor_cmd_start <= 1'b1;
        @(posedge ref_clk) vendor_cmd_start <= 1'b0;
        rd(8'h05);
        chk("cleared count", 8'h00, reg_rdata);
        // forwarded window goes out to the peripheral and back
        wr(8'hF5, 8'h3C);
        rd(8'hF5);
        chk("periph read", 8'h3C, reg_rdata);
        chk("periph addr", 8'h35, 8'(peripheral_address_line));
        // alternate functions take aux 2..0 even with the data register cleared
        @(posedge ref_clk) suspend_active <= 1'b1;
        wr(8'h12, 8'h00);
        wr(8'h00, 8'h1D);
        rd(8'h00);
        chk("aux alternate", 8'h03, 8'(aux_out));
        chk("control pins", 8'h07, {5'h00, subscriber_bus_reset, usb_reset_response_en,
            peripheral_reset_out_n});
        // audio class control set
        @(posedge ref_clk) audio_class_mode <= 1'b1;
        wr(8'h1F, 8'hFF);
        rd(8'h1F);
        chk("audio ctrl", 8'h7E, reg_rdata);
        chk("tdm reset", 8'h01, 8'(tdm_reset));
        chk("master", 8'h01, 8'(serial_pins_output));
        chk("usb reset en", 8'h01, 8'(usb_reset_response_en));
        chk("dout enable", 8'h00, 8'(dout_enable));
        chk("force low", 8'h01, 8'(dout_force_low));
        chk("clock invert", 8'h01, 8'(serial_clk_invert));
        chk("audio gating", 8'h00, {5'h00, clk_doubler_en, subscriber_bus_reset,
            tdm_clk_out_invert});
        wr(8'h1F, 8'h00);
        rd(8'h1F);
        chk("tdm reset", 8'h00, 8'(tdm_reset));
        chk("master", 8'h00, 8'(serial_pins_output));
        chk("dout enable", 8'h01, 8'(dout_enable));
        // second reset in mid-run restores the defaults
        @(posedge ref_clk) audio_class_mode <= 1'b0;
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rd(8'h00);
        chk("control default", 8'h40, reg_rdata);
        chk("usb reset en", 8'h00, 8'(usb_reset_response_en));
        chk("clock gate", 8'h00, 8'(parallel_clock_output_disable));
        chk("gain step", 8'h02, 8'(mic_gain_step));
        print_verdict();
    end
endmodule
`default_nettype wire
